//--- include/pfrs_defs.vh
// Constants for the power-fail reset sequencer.
// Assumes one 25 MHz system clock; ring and crystal ticks arrive as enables.
// What this block does
// - Monitor interval: continuous, 2^11, 2^12, 2^13 ring clocks
// - Periodic episode enables comparator three ring cycles
// - Above reset level third ring cycle of window: warmup, restart 8000h
// - Pin/watchdog reset: keep all on, release under 20
// - Power-fail: reset CPU, regulator crystal off, retain
// - Qualified warning level sets flag, CPU keeps running
// - Stop mode warning: power up, warmup, wake CPU
// - Stop mode: monitor on, regulator crystal off, retain
// - Below power-on level: everything off, held reset
// - Power-up: regulator crystal on, reset through warmup
// - Reset and warning level dips shorter than qualify window are ignored
`ifndef PFRS_DEFS_VH
`define PFRS_DEFS_VH

`define PFRS_INTV_CONT     2'h0
`define PFRS_INTV_2P11     2'h1
`define PFRS_INTV_2P12     2'h2
`define PFRS_INTV_2P13     2'h3
`define PFRS_PER_2P11      14'h0800
`define PFRS_PER_2P12      14'h1000
`define PFRS_PER_2P13      14'h2000
`define PFRS_DETECT_CYC    2'h2
`define PFRS_RESTART_ADDR  16'h8000
`define PFRS_EXT_REL_CYC   5'h13
`define PFRS_WARMUP_CYC    16'h1000
`define PFRS_QUAL_CYC      8'h10

`endif

//--- verilog/pfrs_qualify.v
// Filter that asserts its output once its input has held for a count of ticks.
// Input must already be synchronised to clk.
`timescale 1ns/1ns
module pfrs_qualify #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         clk,
    input  wire         arst_n,
    // Sample
    input  wire         tick,
    input  wire [W-1:0] limit,
    input  wire         level,
    // Result
    output reg          qualified
);
    reg [W-1:0] count_reg;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= {W{1'b0}};
            qualified <= 1'b0;
        end else if (!level) begin
            // A short dip never reaches the limit and leaves no trace
            count_reg <= {W{1'b0}};
            qualified <= 1'b0;
        end else if (tick && !qualified) begin
            if (count_reg + 1'b1 >= limit)
                qualified <= 1'b1;
            count_reg <= count_reg + 1'b1;
        end
    end
endmodule

//--- verilog/pfrs_sequencer.v
// Power-fail reset sequencer: supply state machine, periodic monitor,
// warning flag and CPU reset release.
// Comparator outputs, reset pin and watchdog are asynchronous and are
// synchronised here; ring and crystal ticks are one-cycle enables on clk.
`timescale 1ns/1ns
`include "pfrs_defs.vh"
module pfrs_sequencer #(
    parameter WARMUP_CYC = `PFRS_WARMUP_CYC,
    parameter QUAL_CYC   = `PFRS_QUAL_CYC
) (
    // Clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // Timebase enables
    input  wire        ring_tick,
    input  wire        xtal_tick,
    // Comparators, high when supply is above the level
    input  wire        above_power_on_threshold,
    input  wire        above_reset_threshold,
    input  wire        above_warning_threshold,
    // Reset sources and CPU state
    input  wire        ext_reset_n,
    input  wire        wdt_reset,
    input  wire        cpu_stop_mode,
    // Software control
    input  wire [1:0]  monitor_interval,
    input  wire        warning_irq_enable,
    input  wire        supply_warning_clear,
    // Outputs
    output reg         cpu_reset,
    output reg         regulator_enable,
    output reg         crystal_enable,
    output reg         sram_retain,
    output reg         monitor_enable,
    output reg         stop_wakeup,
    output reg  [15:0] restart_addr,
    output reg         supply_warning_flag,
    output wire        warning_irq
);
    localparam S_OFF    = 6'h01;
    localparam S_WARMUP = 6'h02;
    localparam S_RUN    = 6'h04;
    localparam S_FAIL   = 6'h08;
    localparam S_STOP   = 6'h10;
    localparam S_WAKE   = 6'h20;

    reg [4:0] s1_reg;
    reg [4:0] s2_reg;
    wire por_ok  = s2_reg[0];
    wire rst_ok  = s2_reg[1];
    wire warn_ok = s2_reg[2];
    wire ext_rst = ~s2_reg[3] | s2_reg[4];

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_reg <= 5'h08;
            s2_reg <= 5'h08;
        end else begin
            s1_reg <= {wdt_reset, ext_reset_n, above_warning_threshold,
                       above_reset_threshold, above_power_on_threshold};
            s2_reg <= s1_reg;
        end
    end

    // Qualified low-supply conditions; shorter dips never qualify
    wire fail_q;
    wire warn_q;
    pfrs_qualify #(.W(8)) u_fail_q (
        .clk       (clk),
        .arst_n    (arst_n),
        .tick      (ring_tick),
        .limit     (QUAL_CYC[7:0]),
        .level     (por_ok & ~rst_ok),
        .qualified (fail_q)
    );
    pfrs_qualify #(.W(8)) u_warn_q (
        .clk       (clk),
        .arst_n    (arst_n),
        .tick      (ring_tick),
        .limit     (QUAL_CYC[7:0]),
        .level     (rst_ok & ~warn_ok),
        .qualified (warn_q)
    );

    reg  [5:0]  state_reg;
    reg  [5:0]  state_next;
    reg  [15:0] warm_reg;
    reg  [13:0] per_reg;
    reg  [1:0]  above_reg;
    reg  [4:0]  ext_reg;
    reg         ext_hold_reg;
    wire        warm_done = (warm_reg >= WARMUP_CYC[15:0]);
    reg  [13:0] period;

    always @* begin
        case (monitor_interval)
            `PFRS_INTV_2P11: period = `PFRS_PER_2P11;
            `PFRS_INTV_2P12: period = `PFRS_PER_2P12;
            `PFRS_INTV_2P13: period = `PFRS_PER_2P13;
            default:         period = 14'h0000;
        endcase
    end

    // Sampling window: comparator on for the detect cycles, then one more
    wire cont      = (monitor_interval == `PFRS_INTV_CONT);
    wire in_window = cont || (per_reg < {12'h000, `PFRS_DETECT_CYC} + 14'h0001);
    wire recovered = (above_reg == 2'h3);

    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_OFF:
                if (por_ok) state_next = S_WARMUP;
            S_WARMUP:
                if (!por_ok) state_next = S_OFF;
                else if (warm_done && rst_ok) state_next = S_RUN;
            S_RUN:
                if (!por_ok) state_next = S_OFF;
                else if (fail_q) state_next = S_FAIL;
                else if (cpu_stop_mode) state_next = S_STOP;
            S_FAIL:
                if (!por_ok) state_next = S_OFF;
                else if (recovered) state_next = S_WARMUP;
            S_STOP:
                if (!por_ok) state_next = S_OFF;
                else if (fail_q) state_next = S_FAIL;
                else if (warn_q) state_next = S_WAKE;
                else if (!cpu_stop_mode) state_next = S_RUN;
            S_WAKE:
                if (!por_ok) state_next = S_OFF;
                else if (fail_q) state_next = S_FAIL;
                // Wait for the CPU to leave stop, or RUN would fall straight back into STOP
                else if (warm_done && !cpu_stop_mode) state_next = S_RUN;
            default:
                state_next = S_OFF;
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg    <= S_OFF;
            warm_reg     <= 16'h0000;
            per_reg      <= 14'h0000;
            above_reg    <= 2'h0;
            ext_reg      <= 5'h00;
            ext_hold_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            // Crystal warmup counter runs only while the crystal is on
            if (state_next != state_reg)
                warm_reg <= 16'h0000;
            else if (xtal_tick && !warm_done)
                warm_reg <= warm_reg + 16'h0001;
            // Wraps on a ring tick so one interval is exactly period ticks
            if (state_reg != S_FAIL || cont)
                per_reg <= 14'h0000;
            else if (ring_tick)
                per_reg <= (per_reg + 14'h0001 >= period) ? 14'h0000 : per_reg + 14'h0001;
            // Count consecutive good ring samples inside the window
            if (state_reg != S_FAIL || !rst_ok || !in_window)
                above_reg <= 2'h0;
            else if (ring_tick && above_reg != 2'h3)
                above_reg <= above_reg + 2'h1;
            if (ext_rst) begin
                ext_hold_reg <= 1'b1;
                ext_reg      <= 5'h00;
            end else if (ext_hold_reg && xtal_tick) begin
                if (ext_reg + 5'h01 >= `PFRS_EXT_REL_CYC)
                    ext_hold_reg <= 1'b0;
                ext_reg <= ext_reg + 5'h01;
            end
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_reset        <= 1'b1;
            regulator_enable <= 1'b0;
            crystal_enable   <= 1'b0;
            sram_retain      <= 1'b0;
            monitor_enable   <= 1'b0;
            stop_wakeup      <= 1'b0;
            restart_addr     <= 16'h0000;
        end else begin
            // Pin and watchdog resets leave the supplies untouched
            // A CPU woken from stop keeps its state, so WAKE does not reset it
            cpu_reset        <= (state_reg != S_RUN && state_reg != S_STOP &&
                                 state_reg != S_WAKE) || ext_hold_reg;
            regulator_enable <= (state_reg == S_WARMUP) || (state_reg == S_RUN) ||
                                (state_reg == S_WAKE);
            crystal_enable   <= (state_reg == S_WARMUP) || (state_reg == S_RUN) ||
                                (state_reg == S_WAKE);
            sram_retain      <= (state_reg == S_FAIL) || (state_reg == S_STOP) ||
                                (state_reg == S_WAKE);
            monitor_enable   <= (state_reg == S_FAIL) ? in_window :
                                (state_reg != S_OFF);
            stop_wakeup      <= (state_reg == S_WAKE) && warm_done;
            if (state_reg == S_FAIL)
                restart_addr <= `PFRS_RESTART_ADDR;
        end
    end

    // Sticky warning flag; a new event beats a clear in the same cycle
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            supply_warning_flag <= 1'b0;
        else if (warn_q && (state_reg == S_RUN || state_reg == S_STOP))
            supply_warning_flag <= 1'b1;
        else if (supply_warning_clear)
            supply_warning_flag <= 1'b0;
    end

    assign warning_irq = supply_warning_flag & warning_irq_enable;
endmodule

//--- tb/pfrs_seq_properties.sv
// Checker for the power-fail reset sequencer, watching its ports only.
// Assumes xtal_tick every second clk while the crystal runs; bound below.
`timescale 1ns/1ns
module pfrs_seq_props #(parameter WARMUP_CYC = 8, parameter QUAL_CYC = 4) (
    input wire clk, input wire arst_n, input wire ring_tick, input wire xtal_tick,
    input wire above_power_on_threshold, input wire above_reset_threshold,
    input wire above_warning_threshold, input wire ext_reset_n, input wire wdt_reset,
    input wire cpu_stop_mode, input wire [1:0] monitor_interval,
    input wire warning_irq_enable, input wire supply_warning_clear,
    input wire cpu_reset, input wire regulator_enable, input wire crystal_enable,
    input wire sram_retain, input wire monitor_enable, input wire stop_wakeup,
    input wire [15:0] restart_addr, input wire supply_warning_flag, input wire warning_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    AST_IRQ_GATE: assert property (
        warning_irq == (supply_warning_flag && warning_irq_enable))
        else $error("irq differs from flag and enable");
    AST_FLAG_HOLD: assert property (
        $fell(supply_warning_flag) |-> $past(supply_warning_clear))
        else $error("warning flag dropped without clear");
    AST_FAIL_OFF: assert property (
        cpu_reset && sram_retain |-> !regulator_enable && !crystal_enable)
        else $error("power fail with regulator or crystal on");
    AST_OFF_ALL: assert property (
        !regulator_enable && !sram_retain |->
        cpu_reset && !crystal_enable && !monitor_enable)
        else $error("off state not fully off");
    AST_WAKE_PWR: assert property (
        stop_wakeup |-> regulator_enable && crystal_enable && !cpu_reset)
        else $error("wakeup without power");
    AST_ADDR: assert property (
        restart_addr != 16'h0 |-> restart_addr == 16'h8000)
        else $error("bad restart address");
    // Two synchroniser stages and two registers before cpu_reset rises
    AST_EXT_HOLD: assert property (
        !ext_reset_n [*5] |-> cpu_reset)
        else $error("cpu runs during pin reset");
    // Cycle bound is 20 crystal cycles of two clocks each plus synchroniser delay
    AST_EXT_REL: assert property (
        $rose(ext_reset_n) && crystal_enable && !sram_retain |-> ##[1:44] !cpu_reset)
        else $error("slow release after pin reset");
    cover property ($rose(supply_warning_flag));
    cover property ($rose(stop_wakeup));
    cover property ($fell(cpu_reset) && restart_addr == 16'h8000);
endmodule
bind pfrs_sequencer pfrs_seq_props #(.WARMUP_CYC(WARMUP_CYC), .QUAL_CYC(QUAL_CYC))
    pfrs_seq_props_inst (.*);

//--- tb/pfrs_partner.sv
// Far side model: ring oscillator, crystal and CPU stop mode.
// Crystal ticks stand still while disabled; the CPU leaves stop on wakeup.
`timescale 1ns/1ns
module pfrs_partner (
    input wire clk, input wire arst_n, input wire crystal_enable, input wire stop_req,
    input wire stop_wakeup, input wire cpu_reset,
    output reg ring_tick, output reg xtal_tick, output reg cpu_stop_mode
);
    reg [1:0] ring_reg;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ring_reg <= 2'h0;
            ring_tick <= 1'b0;
            xtal_tick <= 1'b0;
            cpu_stop_mode <= 1'b0;
        end else begin
            ring_reg <= ring_reg + 2'h1;
            ring_tick <= (ring_reg == 2'h3);
            xtal_tick <= crystal_enable && !xtal_tick;
            cpu_stop_mode <= stop_req || (cpu_stop_mode && !stop_wakeup && !cpu_reset);
        end
    end
endmodule

//--- tb/pfrs_sequencer_tb_top.sv
// Self-checking bench for the power-fail reset sequencer.
// Shortened warmup and qualify counts keep the run brief.
`timescale 1ns/1ns
module pfrs_sequencer_tb_top;
    reg clk, arst_n, por, rok, wok, ext_n, wdt, stop_req, irq_en, clr;
    reg [1:0] intv;
    wire rt, xt, stp, cpu_reset, reg_en, xtal_en, retain, mon, wake, flag, irq;
    wire [15:0] addr;
    wire [4:0] obs = {mon, cpu_reset, reg_en, wake, flag};
    integer error_cnt = 0, total_checks = 0, seed = 32'haa786e6e, i, k;
    pfrs_sequencer #(.WARMUP_CYC(8), .QUAL_CYC(4)) pfrs_sequencer_inst (.clk(clk),
        .arst_n(arst_n), .ring_tick(rt), .xtal_tick(xt), .above_power_on_threshold(por),
        .above_reset_threshold(rok), .above_warning_threshold(wok), .ext_reset_n(ext_n),
        .wdt_reset(wdt), .cpu_stop_mode(stp), .monitor_interval(intv),
        .warning_irq_enable(irq_en), .supply_warning_clear(clr), .cpu_reset(cpu_reset),
        .regulator_enable(reg_en), .crystal_enable(xtal_en), .sram_retain(retain),
        .monitor_enable(mon), .stop_wakeup(wake), .restart_addr(addr),
        .supply_warning_flag(flag), .warning_irq(irq));
    pfrs_partner pfrs_partner_inst (.clk(clk), .arst_n(arst_n), .crystal_enable(xtal_en),
        .stop_req(stop_req), .stop_wakeup(wake), .cpu_reset(cpu_reset), .ring_tick(rt),
        .xtal_tick(xt), .cpu_stop_mode(stp));
    function exp_irq(input f, input e);
        exp_irq = f & e;
    endfunction
    function integer exp_off(input integer n);
        exp_off = ((1 << (10 + n)) - 3) * 4;
    endfunction
    task chk(input [16:0] got, input [16:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task step(input integer n);
        begin
            repeat (n) @(posedge clk);
            #2;
        end
    endtask
    task wait_bit(input integer b, input v, input integer n);
        begin
            k = 0;
            while (obs[b] !== v && k < n) begin
                step(1);
                k = k + 1;
            end
        end
    endtask
    task close_out;
        begin
            if (error_cnt == 0 && total_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    initial begin
        #(90000 * 40);
        error_cnt = error_cnt + 1;
        close_out;
    end
    initial begin
        {arst_n, wdt, stop_req, clr, intv} = 0;
        {por, rok, wok, ext_n} = 4'hf;
        irq_en = $random(seed);
        step(6);
        arst_n = 1;
        wait_bit(2, 1, 20);
        chk({cpu_reset, xtal_en, addr == 16'h0}, 3'b111);
        wait_bit(3, 0, 100);
        chk(reg_en, 1);
        for (i = 0; i < 2; i = i + 1) begin
            wok = 0;
            rok = i;
            step(4 + ($random(seed) & 7));
            {rok, wok} = 2'b11;
            step(20);
            chk({cpu_reset, flag}, 0);
        end
        wok = 0;
        wait_bit(0, 1, 60);
        wok = 1;
        chk({flag, cpu_reset, irq}, {2'b10, exp_irq(1'b1, irq_en)});
        step(40);
        chk(flag, 1);
        clr = 1;
        step(1);
        clr = 0;
        step(1);
        chk(flag, 0);
        for (i = 0; i < 2; i = i + 1) begin
            ext_n = i[0];
            wdt = i[0];
            step(8);
            chk({cpu_reset, reg_en, xtal_en}, 3'b111);
            {ext_n, wdt} = 2'b10;
            wait_bit(3, 0, 44);
            chk(cpu_reset, 0);
        end
        stop_req = 1;
        step(1);
        stop_req = 0;
        step(6);
        chk({reg_en, xtal_en, mon, retain, cpu_reset}, 5'b00110);
        wok = 0;
        wait_bit(1, 1, 200);
        wok = 1;
        chk({reg_en, xtal_en, cpu_reset}, 3'b110);
        chk(wake, 1);
        step(2);
        chk(stp, 0);
        for (i = 0; i < 4; i = i + 1) begin
            intv = i;
            {rok, wok} = 2'b00;
            wait_bit(2, 0, 80);
            chk({cpu_reset, reg_en, xtal_en, retain}, 4'b1001);
            wait_bit(4, 1, (i == 0) ? 2 : 40000);
            wait_bit(4, 0, (i == 0) ? 60 : 40);
            if (i == 0)
                chk(mon, 1);
            {rok, wok} = 2'b11;
            wait_bit(4, 1, 40000);
            if (i > 0)
                chk(k > exp_off(i) - 9 && k < exp_off(i) + 9, 1);
            wait_bit(3, 0, 40000);
            chk({cpu_reset, addr}, 17'h08000);
        end
        {por, rok, wok} = 3'b000;
        step(10);
        chk({cpu_reset, reg_en, xtal_en, mon, retain}, 5'b10000);
        close_out;
    end
endmodule
